// ---- design/pts_map.vh ----
`ifndef PTS_MAP_VH
`define PTS_MAP_VH

// ****************************************
// Bus command codes (C/BE# in address phase)
// ****************************************
`define PTS_CMD_IO_RD 4'h2
`define PTS_CMD_IO_WR 4'h3
`define PTS_CMD_MEM_RD 4'h6
`define PTS_CMD_MEM_WR 4'h7
`define PTS_CMD_CFG_RD 4'ha
`define PTS_CMD_CFG_WR 4'hb
`define PTS_CMD_MEM_RD_MUL 4'hc
`define PTS_CMD_MEM_RD_LINE 4'he
`define PTS_CMD_MEM_WR_INV 4'hf

// ****************************************
// Window sizes as lowest compared address bit
// ****************************************
`define PTS_CSR_MEM_LSB 12
`define PTS_CSR_IO_LSB 6
`define PTS_FLASH_LSB 17
`define PTS_CIS_LSB 12
`define PTS_FLASH_AW 17

// ****************************************
// Configuration command and status bits
// ****************************************
`define PTS_CMDB_IO_EN 0
`define PTS_CMDB_MEM_EN 1
`define PTS_CMDB_PERR_RESP 6
`define PTS_CMDB_SERR_EN 8
`define PTS_STSB_SIG_SERR 14
`define PTS_STSB_DET_PERR 15
`define PTS_STATUS_RESET 16'h0000

// ****************************************
// Timing counts in PCI clocks
// ****************************************
`define PTS_FLASH_WAIT 8'h04
`define PTS_MODEM_TIMEOUT 8'h07
`define PTS_SYNC_DELAY 8'h02

`endif

// ---- design/pts_target.v ----
`timescale 1ns/100ps
`include "pts_map.vh"

module pts_target #(
  parameter [7:0] FLASH_WAIT = `PTS_FLASH_WAIT
) (
  input wire core_clk,
  input wire reset,
  input wire [31:0] ad_in,
  output wire [31:0] ad_out,
  output wire ad_oe,
  input wire [3:0] cbe_n_in,
  input wire par_in,
  output wire par_out,
  output wire par_oe,
  input wire frame_n_in,
  input wire irdy_n_in,
  input wire idsel_in,
  output wire devsel_n_out,
  output wire devsel_n_oe,
  output wire trdy_n_out,
  output wire trdy_n_oe,
  output wire stop_n_out,
  output wire stop_n_oe,
  output wire perr_n_out,
  output wire perr_n_oe,
  output wire serr_n_out,
  output wire serr_n_oe,
  input wire [31:0] csr_mem_base,
  input wire [31:0] csr_io_base,
  input wire [31:0] flash_base,
  input wire [31:0] cis_base,
  input wire [15:0] cfg_command,
  output wire [15:0] cfg_status,
  input wire [15:0] cfg_status_clear,
  input wire cardbus_mode,
  input wire modem_mode,
  input wire eeprom_load_done,
  output wire reg_rd,
  output wire reg_is_cfg,
  output wire reg_is_io,
  output wire [11:0] reg_addr,
  input wire [31:0] reg_rdata,
  output wire reg_wr,
  output wire [31:0] reg_wdata,
  output wire [3:0] reg_be,
  output wire ext_rd,
  output wire ext_wr,
  output wire ext_word,
  output wire [16:0] ext_addr,
  output wire [7:0] ext_wdata,
  input wire [15:0] ext_rdata,
  output wire modem_chip_select_n,
  input wire modem_ready
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_CLAIM = 3'h1;
  localparam [2:0] ST_WAIT = 3'h2;
  localparam [2:0] ST_DATA = 3'h3;
  localparam [2:0] ST_TURN = 3'h4;

  localparam [2:0] K_NONE = 3'h0;
  localparam [2:0] K_CSR = 3'h1;
  localparam [2:0] K_CFG = 3'h2;
  localparam [2:0] K_FLASH = 3'h3;
  localparam [2:0] K_MODEM = 3'h4;
  localparam [2:0] K_RETRY = 3'h5;
  localparam [15:0] STATUS_RST = `PTS_STATUS_RESET;

  reg [2:0] state_q;
  reg [2:0] kind_q;
  reg wr_q;
  reg io_q;
  reg [31:0] addr_q;
  reg drv_oe_q;
  reg devsel_q;
  reg trdy_q;
  reg stop_q;
  reg ad_oe_q;
  reg [31:0] ad_out_q;
  reg par_q;
  reg par_oe_q;
  reg reg_wr_q;
  reg [31:0] reg_wdata_q;
  reg [3:0] reg_be_q;
  reg ext_rd_q;
  reg ext_wr_q;
  reg ext_word_q;
  reg [16:0] ext_addr_q;
  reg [7:0] ext_wdata_q;
  reg modem_cs_q;
  reg frame_prev_q;
  reg apar_chk_q;
  reg apar_calc_q;
  reg dpar_chk_q;
  reg dpar_calc_q;
  reg det_perr_q;
  reg sig_serr_q;
  reg perr_q;
  reg perr_tail_q;
  reg serr_q;
  reg mr_s1_q;
  reg mr_s2_q;
  reg [2:0] kind_d;
  reg [1:0] lane;
  reg [7:0] lane_byte;

  wire [3:0] cmd = cbe_n_in;
  wire addr_phase = !frame_n_in && frame_prev_q;
  wire perr_en = cfg_command[`PTS_CMDB_PERR_RESP];
  wire serr_en = cfg_command[`PTS_CMDB_SERR_EN];
  wire [3:0] be = ~cbe_n_in;
  wire cmd_io = (cmd == `PTS_CMD_IO_RD) || (cmd == `PTS_CMD_IO_WR);
  wire cmd_cfg = (cmd == `PTS_CMD_CFG_RD) || (cmd == `PTS_CMD_CFG_WR);
  wire cmd_mem = (cmd == `PTS_CMD_MEM_RD) || (cmd == `PTS_CMD_MEM_WR) ||
                 (cmd == `PTS_CMD_MEM_RD_MUL) || (cmd == `PTS_CMD_MEM_RD_LINE) ||
                 (cmd == `PTS_CMD_MEM_WR_INV);
  wire mem_ok = cmd_mem && cfg_command[`PTS_CMDB_MEM_EN];
  wire hit_io = cmd_io && cfg_command[`PTS_CMDB_IO_EN] &&
    (ad_in[31:`PTS_CSR_IO_LSB] == csr_io_base[31:`PTS_CSR_IO_LSB]);
  wire hit_csr = mem_ok &&
    (ad_in[31:`PTS_CSR_MEM_LSB] == csr_mem_base[31:`PTS_CSR_MEM_LSB]);
  wire hit_flash = mem_ok &&
    (ad_in[31:`PTS_FLASH_LSB] == flash_base[31:`PTS_FLASH_LSB]);
  wire hit_cis = mem_ok && cardbus_mode &&
    (ad_in[31:`PTS_CIS_LSB] == cis_base[31:`PTS_CIS_LSB]);
  wire hit_cfg = cmd_cfg && idsel_in && (ad_in[1:0] == 2'b00);
  wire ext_kind = (kind_q == K_FLASH) || (kind_q == K_MODEM);
  wire ext_start = (state_q == ST_CLAIM) && ext_kind && (!wr_q || !irdy_n_in);
  wire fl_start = ext_start && (kind_q == K_FLASH);
  wire md_start = ext_start && (kind_q == K_MODEM);
  wire fl_done;
  wire md_timeout;
  wire xfer = (state_q == ST_DATA) && !irdy_n_in && (trdy_q || stop_q);

  // ****************************************
  // Address decode
  // ****************************************
  // Decode ignores address parity so a bad address still completes
  always @* begin
    kind_d = K_NONE;
    if (hit_cfg) begin
      kind_d = eeprom_load_done ? K_CFG : K_RETRY;
    end else if (hit_io || hit_csr) begin
      kind_d = K_CSR;
    end else if (hit_cis) begin
      kind_d = K_RETRY;
    end else if (hit_flash) begin
      kind_d = modem_mode ? K_MODEM : K_FLASH;
    end
  end

  // Lowest enabled lane picks the flash byte; a word read uses lanes 0-1 or 2-3
  always @* begin
    lane = 2'd3;
    if (be[0]) begin
      lane = 2'd0;
    end else if (be[1]) begin
      lane = 2'd1;
    end else if (be[2]) begin
      lane = 2'd2;
    end
    case (lane)
      2'd0: lane_byte = ad_in[7:0];
      2'd1: lane_byte = ad_in[15:8];
      2'd2: lane_byte = ad_in[23:16];
      default: lane_byte = ad_in[31:24];
    endcase
  end

  // ****************************************
  // Slow-access timers
  // ****************************************
  pts_wait_cnt u_flash_wait (
    .core_clk(core_clk),
    .reset(reset),
    .start(fl_start),
    .count(FLASH_WAIT),
    .expired(fl_done)
  );

  // Ready passes a two-stage synchroniser, so its latency joins the limit
  pts_wait_cnt u_modem_wait (
    .core_clk(core_clk),
    .reset(reset),
    .start(md_start),
    .count(`PTS_MODEM_TIMEOUT + `PTS_SYNC_DELAY),
    .expired(md_timeout)
  );

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mr_s1_q <= 1'b0;
      mr_s2_q <= 1'b0;
    end else begin
      mr_s1_q <= modem_ready;
      mr_s2_q <= mr_s1_q;
    end
  end

  // ****************************************
  // Target state machine
  // ****************************************
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_IDLE;
      kind_q <= K_NONE;
      wr_q <= 1'b0;
      io_q <= 1'b0;
      addr_q <= 32'h00000000;
      drv_oe_q <= 1'b0;
      devsel_q <= 1'b0;
      trdy_q <= 1'b0;
      stop_q <= 1'b0;
      ad_oe_q <= 1'b0;
      ad_out_q <= 32'h00000000;
      reg_wr_q <= 1'b0;
      reg_wdata_q <= 32'h00000000;
      reg_be_q <= 4'h0;
      ext_rd_q <= 1'b0;
      ext_wr_q <= 1'b0;
      ext_word_q <= 1'b0;
      ext_addr_q <= 17'h00000;
      ext_wdata_q <= 8'h00;
      modem_cs_q <= 1'b0;
    end else begin
      reg_wr_q <= 1'b0;
      ext_rd_q <= 1'b0;
      ext_wr_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (addr_phase && kind_d != K_NONE) begin
            state_q <= ST_CLAIM;
            kind_q <= kind_d;
            wr_q <= cmd[0];
            io_q <= cmd_io;
            addr_q <= ad_in;
            drv_oe_q <= 1'b1;
            devsel_q <= 1'b1;
          end
        end
        ST_CLAIM: begin
          case (kind_q)
            K_CSR, K_CFG: begin
              ad_out_q <= reg_rdata;
              ad_oe_q <= !wr_q;
              trdy_q <= 1'b1;
              stop_q <= 1'b1;
              state_q <= ST_DATA;
            end
            K_FLASH, K_MODEM: begin
              if (ext_start) begin
                ext_addr_q <= {addr_q[`PTS_FLASH_AW-1:2], lane};
                ext_word_q <= !wr_q && (be == 4'h3 || be == 4'hc);
                ext_wdata_q <= lane_byte;
                ext_rd_q <= !wr_q;
                ext_wr_q <= wr_q;
                modem_cs_q <= (kind_q == K_MODEM);
                state_q <= ST_WAIT;
              end
            end
            default: begin
              // Retried requester owes nothing; next attempt decodes fresh
              stop_q <= 1'b1;
              state_q <= ST_DATA;
            end
          endcase
        end
        ST_WAIT: begin
          // TRDY stays off until the flash has delivered or taken the byte
          if ((kind_q == K_FLASH && fl_done) || (kind_q == K_MODEM && mr_s2_q)) begin
            ad_out_q <= ext_word_q ? {ext_rdata, ext_rdata} : {4{ext_rdata[7:0]}};
            ad_oe_q <= !wr_q;
            trdy_q <= 1'b1;
            stop_q <= 1'b1;
            modem_cs_q <= 1'b0;
            state_q <= ST_DATA;
          end else if (kind_q == K_MODEM && md_timeout) begin
            stop_q <= 1'b1;
            modem_cs_q <= 1'b0;
            state_q <= ST_DATA;
          end
        end
        ST_DATA: begin
          // A data parity error does not alter this path
          if (xfer) begin
            if (trdy_q && wr_q && (kind_q == K_CSR || kind_q == K_CFG)) begin
              reg_wr_q <= 1'b1;
              reg_wdata_q <= ad_in;
              reg_be_q <= be;
            end
            trdy_q <= 1'b0;
            ad_oe_q <= 1'b0;
            // STOP holds until the initiator drops FRAME# on its last phase
            if (frame_n_in) begin
              devsel_q <= 1'b0;
              stop_q <= 1'b0;
              state_q <= ST_TURN;
            end
          end
        end
        ST_TURN: begin
          drv_oe_q <= 1'b0;
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Parity generation and checking
  // ****************************************
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      frame_prev_q <= 1'b1;
      par_q <= 1'b0;
      par_oe_q <= 1'b0;
      apar_chk_q <= 1'b0;
      apar_calc_q <= 1'b0;
      dpar_chk_q <= 1'b0;
      dpar_calc_q <= 1'b0;
      perr_q <= 1'b0;
      perr_tail_q <= 1'b0;
      serr_q <= 1'b0;
    end else begin
      frame_prev_q <= frame_n_in;
      par_q <= ^{ad_out_q, cbe_n_in};
      par_oe_q <= ad_oe_q;
      // Every address phase is checked, claimed or not
      apar_chk_q <= addr_phase;
      apar_calc_q <= ^{ad_in, cbe_n_in};
      dpar_chk_q <= xfer && trdy_q && wr_q;
      dpar_calc_q <= ^{ad_in, cbe_n_in};
      perr_q <= dpar_chk_q && (par_in != dpar_calc_q) && perr_en;
      perr_tail_q <= perr_q;
      serr_q <= apar_chk_q && (par_in != apar_calc_q) && perr_en && serr_en;
    end
  end

  // Sticky status: a new error in the clearing cycle keeps its bit
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      det_perr_q <= STATUS_RST[`PTS_STSB_DET_PERR];
      sig_serr_q <= STATUS_RST[`PTS_STSB_SIG_SERR];
    end else begin
      if ((dpar_chk_q || apar_chk_q) && (par_in != (dpar_chk_q ? dpar_calc_q : apar_calc_q))) begin
        det_perr_q <= 1'b1;
      end else if (cfg_status_clear[`PTS_STSB_DET_PERR]) begin
        det_perr_q <= 1'b0;
      end
      if (apar_chk_q && (par_in != apar_calc_q) && perr_en && serr_en) begin
        sig_serr_q <= 1'b1;
      end else if (cfg_status_clear[`PTS_STSB_SIG_SERR]) begin
        sig_serr_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign ad_out = ad_out_q;
  assign ad_oe = ad_oe_q;
  assign par_out = par_q;
  assign par_oe = par_oe_q;
  assign devsel_n_out = ~devsel_q;
  assign devsel_n_oe = drv_oe_q;
  assign trdy_n_out = ~trdy_q;
  assign trdy_n_oe = drv_oe_q;
  assign stop_n_out = ~stop_q;
  assign stop_n_oe = drv_oe_q;
  assign perr_n_out = ~perr_q;
  assign perr_n_oe = perr_q | perr_tail_q;
  assign serr_n_out = 1'b0;
  assign serr_n_oe = serr_q;
  assign cfg_status = {det_perr_q, sig_serr_q, 14'h0000};
  assign reg_rd = (state_q == ST_CLAIM) && !wr_q && (kind_q == K_CSR || kind_q == K_CFG);
  assign reg_is_cfg = (kind_q == K_CFG);
  assign reg_is_io = io_q;
  assign reg_addr = addr_q[11:0];
  assign reg_wr = reg_wr_q;
  assign reg_wdata = reg_wdata_q;
  assign reg_be = reg_be_q;
  assign ext_rd = ext_rd_q;
  assign ext_wr = ext_wr_q;
  assign ext_word = ext_word_q;
  assign ext_addr = ext_addr_q;
  assign ext_wdata = ext_wdata_q;
  assign modem_chip_select_n = ~modem_cs_q;

endmodule // pts_target

// ---- design/pts_target_dummy_guard.v ----
`timescale 1ns/100ps
// ****************************************
// Intentionally empty compile unit
// ****************************************

// ---- design/pts_wait_cnt.v ----
`timescale 1ns/100ps

// ****************************************
// One-shot down counter: expired pulses count clocks after start
// ****************************************
module pts_wait_cnt (
  input wire core_clk,
  input wire reset,
  input wire start,
  input wire [7:0] count,
  output reg expired
);

  reg [7:0] cnt_q;
  reg run_q;

  // A count of zero is treated as one so the pulse is never lost
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cnt_q <= 8'h00;
      run_q <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (start) begin
        cnt_q <= count;
        run_q <= 1'b1;
      end else if (run_q) begin
        if (cnt_q <= 8'h01) begin
          run_q <= 1'b0;
          expired <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 8'h01;
        end
      end
    end
  end

endmodule // pts_wait_cnt

// ---- sim/pts_host_model.sv ----
`timescale 1ns/100ps

// ****************************************
// Initiator model: one single-phase transaction at a time
// ****************************************
module pts_host_model (
  input wire core_clk,
  input wire [31:0] ad_bus,
  input wire trdy_n,
  input wire stop_n,
  output reg [31:0] ad_h,
  output reg [3:0] cbe_h,
  output reg par_h,
  output reg frame_n,
  output reg irdy_n,
  output reg idsel
);
  reg flip = 1'b0;

  initial begin
    ad_h = 32'h0;
    cbe_h = 4'hf;
    par_h = 1'b0;
    frame_n = 1'b1;
    irdy_n = 1'b1;
    idsel = 1'b0;
  end

  // Even parity of the previous cycle; flip injects an error on purpose
  always @(posedge core_clk) begin
    par_h <= #1 (^{ad_bus, cbe_h}) ^ flip;
  end

  task xfer(input [3:0] cmd, input [31:0] adr, input [3:0] be, input [31:0] wd,
            input [1:0] stall, input [1:0] bad, output [1:0] how);
    integer n;
    begin
      @(posedge core_clk) #1;
      frame_n = 1'b0;
      ad_h = adr;
      cbe_h = cmd;
      idsel = (cmd[3:1] == 3'b101);
      flip = bad[0];
      @(posedge core_clk) #1;
      cbe_h = be;
      flip = bad[1];
      ad_h = cmd[0] ? wd : ~adr;
      repeat (stall) @(posedge core_clk) #1;
      frame_n = 1'b1;
      irdy_n = 1'b0;
      n = 0;
      @(posedge core_clk);
      while (trdy_n && stop_n && n < 16) begin
        n = n + 1;
        @(posedge core_clk);
      end
      how = {~trdy_n, ~stop_n};
      #1;
      irdy_n = 1'b1;
      ad_h = ~ad_h;
      cbe_h = 4'hf;
      idsel = 1'b0;
      flip = 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
    end
  endtask
endmodule // pts_host_model

// ---- sim/pts_target_monitor.sv ----
`timescale 1ns/100ps

// ****************************************
// Port checker for the target slave port
// ****************************************
module pts_target_monitor #(
  parameter [7:0] FLASH_WAIT = 8'h04
) (
  input wire core_clk,
  input wire reset,
  input wire [31:0] ad_in,
  input wire [3:0] cbe_n_in,
  input wire frame_n_in,
  input wire irdy_n_in,
  input wire idsel_in,
  input wire devsel_n_out,
  input wire trdy_n_out,
  input wire trdy_n_oe,
  input wire stop_n_out,
  input wire stop_n_oe,
  input wire perr_n_out,
  input wire perr_n_oe,
  input wire serr_n_oe,
  input wire [15:0] cfg_command,
  input wire [15:0] cfg_status,
  input wire modem_mode,
  input wire eeprom_load_done,
  input wire reg_rd,
  input wire ext_rd
);
  // Modem reads share the strobe but wait on the ready input, so they are not counted
  reg [7:0] wait_q;
  wire tgt_trdy = trdy_n_oe && !trdy_n_out;

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wait_q <= 8'h00;
    end else if (ext_rd && !modem_mode) begin
      wait_q <= 8'h01;
    end else if (wait_q != 8'h00 && tgt_trdy) begin
      wait_q <= 8'h00;
    end else if (wait_q != 8'h00) begin
      wait_q <= wait_q + 8'h01;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // The counter's expiry pulse is registered, so TRDY# follows one clock after the count
  a_flash_wait_count: assert property ((tgt_trdy && wait_q != 8'h00) |-> wait_q == FLASH_WAIT + 8'h01)
    else $error("flash read wait count wrong");
  a_reg_zero_wait: assert property (reg_rd |=> tgt_trdy && stop_n_oe && !stop_n_out)
    else $error("register read not completed without wait");
  a_phase_stops: assert property ((tgt_trdy && !irdy_n_in) |-> stop_n_oe && !stop_n_out)
    else $error("data phase without disconnect");
  a_trdy_stands: assert property ((tgt_trdy && irdy_n_in) |=> tgt_trdy)
    else $error("ready dropped during initiator wait");
  a_cfg_early_retry: assert property (($fell(frame_n_in) && idsel_in && cbe_n_in[3:1] == 3'b101
    && ad_in[1:0] == 2'b00 && !eeprom_load_done) |-> ##1 !devsel_n_out ##1 (!stop_n_out && !tgt_trdy))
    else $error("configuration cycle not retried");
  a_perr_gated: assert property ((perr_n_oe && !perr_n_out) |-> cfg_command[6] ##[0:2] cfg_status[15])
    else $error("parity error signalled while disabled");
  a_serr_one_clock: assert property (serr_n_oe |-> cfg_command[6] && cfg_command[8] ##1 !serr_n_oe)
    else $error("system error pulse wrong");
  a_serr_status: assert property (serr_n_oe |-> ##[0:1] (cfg_status[14] && cfg_status[15]))
    else $error("system error status not set");

  cover property (tgt_trdy && !irdy_n_in && wait_q != 8'h00);
  cover property (serr_n_oe);
  cover property (stop_n_oe && !stop_n_out && !tgt_trdy && !irdy_n_in);
endmodule // pts_target_monitor

// ---- sim/pts_target_tb.sv ----
`timescale 1ns/100ps
module pts_target_tb;
  localparam [31:0] CSRM = 32'h4000_0000, CSRIO = 32'h0000_1000, RDX = 32'ha5a5_0000;
  localparam [31:0] FLB = 32'h8000_0000, CISB = 32'h9000_0000, CMDS = 32'hb3f7_2ec6;
  localparam [23:0] BES = 24'h3c7bde;
  localparam [63:0] EDGE = 64'h0040_003c_1000_0ffc;
  reg core_clk = 1'b0;
  reg reset = 1'b1;
  reg [15:0] cfg_command = 16'h0003;
  reg [15:0] cfg_status_clear = 16'h0000;
  reg cardbus_mode = 1'b0, modem_mode = 1'b0, eeprom_load_done = 1'b0, modem_ready = 1'b0;
  reg [7:0] mdm_dly = 8'h02, mdm_cnt = 8'h00;
  integer seed = 28, fail_count = 0, cmp_count = 0, perr_cnt = 0, i;
  reg [34:0] bus_q[$];
  reg [63:0] wr_q[$];
  reg [34:0] e;
  reg [31:0] a, d = 32'h0, r;
  reg [3:0] c, be;
  reg [1:0] how, l;
  reg [16:0] ea;
  wire [31:0] ad_out, ad_h, reg_wdata;
  wire [3:0] cbe_h, reg_be;
  wire [15:0] cfg_status;
  wire [11:0] reg_addr;
  wire [16:0] ext_addr;
  wire [7:0] ext_wdata;
  wire ad_oe, par_out, par_oe, par_h, frame_n, irdy_n, idsel, devsel_n_out, devsel_n_oe;
  wire trdy_n_out, trdy_n_oe, stop_n_out, stop_n_oe, perr_n_out, perr_n_oe;
  wire reg_wr, ext_wr, modem_chip_select_n;
  wire [31:0] ad_in = ad_oe ? ad_out : ad_h;
  wire par_in = par_oe ? par_out : par_h;
  wire [31:0] reg_rdata = {20'h0, reg_addr} ^ RDX;
  wire [15:0] ext_rdata = {ext_addr[7:0] ^ 8'h3c, ext_addr[7:0]};

  pts_target #(.FLASH_WAIT(8'h03)) dut_u (.core_clk(core_clk), .reset(reset), .ad_in(ad_in),
    .ad_out(ad_out), .ad_oe(ad_oe), .cbe_n_in(cbe_h), .par_in(par_in), .par_out(par_out),
    .par_oe(par_oe), .frame_n_in(frame_n), .irdy_n_in(irdy_n), .idsel_in(idsel),
    .devsel_n_out(devsel_n_out), .devsel_n_oe(devsel_n_oe), .trdy_n_out(trdy_n_out),
    .trdy_n_oe(trdy_n_oe), .stop_n_out(stop_n_out), .stop_n_oe(stop_n_oe),
    .perr_n_out(perr_n_out), .perr_n_oe(perr_n_oe), .serr_n_out(), .serr_n_oe(),
    .csr_mem_base(CSRM), .csr_io_base(CSRIO), .flash_base(FLB), .cis_base(CISB),
    .cfg_command(cfg_command), .cfg_status(cfg_status), .cfg_status_clear(cfg_status_clear),
    .cardbus_mode(cardbus_mode), .modem_mode(modem_mode), .eeprom_load_done(eeprom_load_done),
    .reg_rd(), .reg_is_cfg(), .reg_is_io(), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_be(reg_be), .ext_rd(), .ext_wr(ext_wr),
    .ext_word(), .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata),
    .modem_chip_select_n(modem_chip_select_n), .modem_ready(modem_ready));

  pts_host_model host_u (.core_clk(core_clk), .ad_bus(ad_in),
    .trdy_n(trdy_n_oe ? trdy_n_out : 1'b1), .stop_n(stop_n_oe ? stop_n_out : 1'b1),
    .ad_h(ad_h), .cbe_h(cbe_h), .par_h(par_h), .frame_n(frame_n), .irdy_n(irdy_n), .idsel(idsel));

  always #20 core_clk = ~core_clk;

  // Modem answers a set number of clocks after its select
  always @(posedge core_clk) begin
    mdm_cnt <= modem_chip_select_n ? 8'h00 : mdm_cnt + 8'h01;
    modem_ready <= #1 !modem_chip_select_n && (mdm_cnt >= mdm_dly);
  end

  task cmp(input [63:0] got, input [63:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  // ****************************************
  // Result watchers: oldest note against each completion
  // ****************************************
  always @(posedge core_clk) begin
    if (!reset && devsel_n_oe && !devsel_n_out && !irdy_n && (!trdy_n_out || !stop_n_out)) begin
      e = (bus_q.size() > 0) ? bus_q.pop_front() : 35'h0;
      cmp({29'h0, e[34], ~trdy_n_out, ~stop_n_out, (e[34] | !ad_oe) ? 32'h0 : ad_out},
          {29'h0, e[34:32], e[34] ? 32'h0 : e[31:0]});
    end
    if (!reset && (reg_wr || ext_wr)) begin
      cmp(reg_wr ? {28'h1, reg_be, reg_wdata} : {39'h0, ext_addr, ext_wdata},
          (wr_q.size() > 0) ? wr_q.pop_front() : 64'h0);
    end
    if (perr_n_oe && !perr_n_out) perr_cnt = perr_cnt + 1;
  end

  // Expected bus result {ignore data, trdy, stop, data}; no note for an unclaimed cycle
  task op(input [3:0] cmd, input [31:0] adr, input [3:0] cbe, input [34:0] exp, input [1:0] bad);
    begin
      r = $random(seed);
      if (exp[33:32] != 2'b00) bus_q.push_back(exp);
      host_u.xfer(cmd, adr, cbe, d, r[1:0], bad, how);
      cmp({62'h0, how}, {62'h0, exp[33:32]});
    end
  endtask

  task sts(input [15:0] exp);
    begin
      @(posedge core_clk) #1;
      cmp({48'h0, cfg_status}, {48'h0, exp});
      cfg_status_clear = 16'hc000;
      @(posedge core_clk) #1;
      cfg_status_clear = 16'h0000;
    end
  endtask

  task tally_and_finish;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
        $display("ALL TESTS PASSED");
      end else begin
        $display("TESTS FAILED");
      end
      $finish;
    end
  endtask

  initial begin
    #800000;
    fail_count = fail_count + 1;
    tally_and_finish;
  end

  initial begin
    repeat (12) @(posedge core_clk);
    #1 reset = 1'b0;
    op(4'ha, 32'h10, 4'h0, 35'h5_0000_0000, 2'b00);
    eeprom_load_done = 1'b1;
    op(4'ha, 32'h04, 4'h0, {3'b011, 32'h004 ^ RDX}, 2'b00);
    $display("config retry test done");
    for (i = 0; i < 16; i = i + 1) begin
      r = $random(seed);
      d = $random(seed);
      c = CMDS[(i % 8) * 4 +: 4];
      a = (c[3:1] == 3'b001) ? CSRIO + r[5:0] : (c[3:1] == 3'b101) ? {20'h0, r[11:2], 2'b00}
        : CSRM + r[11:0];
      if (c[0]) wr_q.push_back({28'h1, ~r[19:16], d});
      op(c, a, r[19:16], c[0] ? 35'h7_0000_0000 : {3'b011, {20'h0, a[11:0]} ^ RDX}, 2'b00);
    end
    for (i = 0; i < 4; i = i + 1) begin
      a = (i < 2 ? CSRM : CSRIO) + EDGE[i * 16 +: 16];
      op(i < 2 ? 4'h6 : 4'h2, a, 4'h0, i[0] ? 35'h0 : {3'b011, {20'h0, a[11:0]} ^ RDX}, 2'b00);
    end
    $display("register window test done");
    for (i = 0; i < 10; i = i + 1) begin
      r = $random(seed);
      d = $random(seed);
      be = BES[(i % 6) * 4 +: 4];
      l = !be[0] ? 2'd0 : !be[1] ? 2'd1 : !be[2] ? 2'd2 : 2'd3;
      a = FLB + {r[16:2], 2'b00};
      ea = {a[16:2], l};
      if (i >= 6) wr_q.push_back({39'h0, ea, d[l * 8 +: 8]});
      op(i >= 6 ? 4'h7 : 4'h6, a, be, i >= 6 ? 35'h7_0000_0000 : (be == 4'hc || be == 4'h3)
        ? {3'b011, {2{ea[7:0] ^ 8'h3c, ea[7:0]}}} : {3'b011, {4{ea[7:0]}}}, 2'b00);
    end
    $display("flash test done");
    cardbus_mode = 1'b1;
    op(4'h6, CISB + 32'h20, 4'h0, 35'h5_0000_0000, 2'b00);
    cardbus_mode = 1'b0;
    modem_mode = 1'b1;
    op(4'h6, FLB + 32'h10, 4'he, 35'h7_0000_0000, 2'b00);
    mdm_dly = 8'h14;
    op(4'h6, FLB + 32'h10, 4'he, 35'h5_0000_0000, 2'b00);
    modem_mode = 1'b0;
    $display("retry kinds test done");
    cfg_command = 16'h0143;
    op(4'h6, 32'h2000_0000, 4'h0, 35'h0, 2'b01);
    sts(16'hc000);
    cfg_command = 16'h0043;
    for (i = 0; i < 3; i = i + 1) begin
      if (i == 2) cfg_command = 16'h0003;
      d = 32'h1234_5670 + i;
      wr_q.push_back({28'h1, 4'hf, d});
      op(4'h7, CSRM + 32'h8, 4'h0, 35'h7_0000_0000, i == 0 ? 2'b01 : 2'b10);
      sts(16'h8000);
    end
    cmp(perr_cnt, 1);
    $display("parity test done");
    cmp(bus_q.size() + wr_q.size(), 0);
    tally_and_finish;
  end
endmodule // pts_target_tb

bind pts_target pts_target_monitor #(.FLASH_WAIT(FLASH_WAIT)) mon_u (.core_clk(core_clk),
  .reset(reset), .ad_in(ad_in), .cbe_n_in(cbe_n_in), .frame_n_in(frame_n_in),
  .irdy_n_in(irdy_n_in), .idsel_in(idsel_in), .devsel_n_out(devsel_n_out),
  .trdy_n_out(trdy_n_out), .trdy_n_oe(trdy_n_oe), .stop_n_out(stop_n_out),
  .stop_n_oe(stop_n_oe), .perr_n_out(perr_n_out), .perr_n_oe(perr_n_oe),
  .serr_n_oe(serr_n_oe), .cfg_command(cfg_command), .cfg_status(cfg_status),
  .modem_mode(modem_mode), .eeprom_load_done(eeprom_load_done), .reg_rd(reg_rd), .ext_rd(ext_rd));
